// >>> hdl/dpllrs_top.sv
// reference selection, switchover and modulator configuration bank
// for the two loops; registers, decoded settings and the automatic
// reference chooser of the second loop
// assumes a host port core delivering byte accesses one per strobe
// and reference valid flags synchronous to core_clk
//
// Operation
// - modulator order: 00 off, 01..11 first to third; resets to third
// - oscillator error gain 0.5, 1, 2, 4 for 00..11; resets to unity
// - dither off for zero, else 1..64 lsbs by powers of two; reset off
// - select: 000 automatic, 001 manual by pin, 100/101 force ref 0/1
// - feedback: 000..011 internal divider, 100/101 external from ref 0/1
// - revert bit: 0 non-revertive, 1 revertive; resets revertive
// - switch phase bit: 0 absorb phase step, 1 track with slope limit
// - ref 0 priority: 00 first, 01 second, others unused; resets first
// - ref 1 priority same encoding; resets to second priority
// - exclude bit set removes that reference from switchover
// - state control: 00 auto, 01 free-run, 10 normal, 11 holdover
// - each reference has a 21-bit pre-divider, reset zero
`timescale 1ns/10ps

`include "dpllrs_regs.svh"

module dpllrs_top
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // host register port
    input  wire logic [15:0] hostAddr,
    input  wire logic        hostWrite,
    input  wire logic        hostRead,
    input  wire logic [7:0]  hostWrData,
    output logic      [7:0]  hostRdData,
    output logic             hostRdValid,
    // reference status
    input  wire logic [1:0]  refValid,
    input  wire logic        gpioRefSel,
    // first loop modulator settings
    output logic      [1:0]  modulatorOrderA,
    output logic             modulatorEnableA,
    output logic      [3:0]  oscErrorGainHalvesA,
    output logic      [6:0]  ditherLsbsA,
    // second loop selection settings
    output logic             revertiveEnableB,
    output logic             switchPhaseModeB,
    output logic      [1:0]  stateForceB,
    output logic             feedbackExternalB,
    output logic             feedbackRefB,
    output logic      [1:0]  activeRefB,
    output logic      [20:0] activePredivB
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // unused priority codes rank below both legal ones
    function automatic logic [1:0] dpllrs_rank(input logic [1:0] pri);
        dpllrs_rank = (pri[1]) ? 2'h2 : {1'b0, pri[0]};
    endfunction : dpllrs_rank

    // pre-divider of a chosen reference; none keeps zero
    function automatic logic [20:0] dpllrs_prediv(
        input dpllrs_pkg::dpllrs_sel_t sel,
        input logic [20:0]             p0,
        input logic [20:0]             p1
    );
        unique case (sel)
            dpllrs_pkg::SEL_REF0: dpllrs_prediv = p0;
            dpllrs_pkg::SEL_REF1: dpllrs_prediv = p1;
            default:              dpllrs_prediv = 21'h000000;
        endcase
    endfunction : dpllrs_prediv

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    localparam dpllrs_pkg::dpllrs_state_t DPLLRS_RST = '{
        modOrder:      `DPLLRS_MOD_ORDER_RST,
        oscGain:       `DPLLRS_OSC_GAIN_RST,
        ditherGain:    `DPLLRS_DITHER_RST,
        refSelMode:    `DPLLRS_REFSEL_RST,
        fbSource:      `DPLLRS_FBSEL_RST,
        revertEn:      `DPLLRS_REVERT_RST,
        phaseMode:     `DPLLRS_SWMODE_RST,
        ref0Pri:       `DPLLRS_PRI0_RST,
        ref1Pri:       `DPLLRS_PRI1_RST,
        ref0Excl:      `DPLLRS_DIS_RST,
        ref1Excl:      `DPLLRS_DIS_RST,
        stateForce:    `DPLLRS_STATE_RST,
        ref0Prediv:    `DPLLRS_PREDIV_RST,
        ref1Prediv:    `DPLLRS_PREDIV_RST,
        sel:           dpllrs_pkg::SEL_NONE,
        activePrediv:  `DPLLRS_PREDIV_RST,
        modEnable:     1'b1,
        oscGainHalves: 4'h2,
        ditherLsbs:    7'h00,
        fbExternal:    1'b0,
        fbRef:         1'b0,
        rdData:        8'h00,
        rdValid:       1'b0
    };

    dpllrs_pkg::dpllrs_state_t state_reg;
    dpllrs_pkg::dpllrs_state_t state_next;
    dpllrs_pkg::dpllrs_sel_t   bestSel;
    logic                      elig0;
    logic                      elig1;
    logic                      curElig;
    logic [7:0]                rdByte;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // one pass: writes, decode, chooser, read capture
    always_comb
    begin
        state_next = state_reg;
        bestSel    = dpllrs_pkg::SEL_NONE;
        rdByte     = 8'h00;

        // register writes; reserved positions are dropped
        if (hostWrite)
        begin
            unique case (hostAddr)
                `DPLLRS_MOD_CFG_ADDR:
                begin
                    state_next.modOrder   =
                        hostWrData[`DPLLRS_MOD_ORDER_LSB +: 2];
                    state_next.oscGain    =
                        hostWrData[`DPLLRS_OSC_GAIN_LSB +: 2];
                    state_next.ditherGain =
                        hostWrData[`DPLLRS_DITHER_LSB +: 3];
                end
                `DPLLRS_SEL_CTRL_ADDR:
                begin
                    state_next.refSelMode =
                        hostWrData[`DPLLRS_REFSEL_LSB +: 3];
                    state_next.fbSource   =
                        hostWrData[`DPLLRS_FBSEL_LSB +: 3];
                    state_next.revertEn   =
                        hostWrData[`DPLLRS_REVERT_BIT];
                    state_next.phaseMode  =
                        hostWrData[`DPLLRS_SWMODE_BIT];
                end
                `DPLLRS_PRIORITY_ADDR:
                begin
                    state_next.ref0Pri =
                        hostWrData[`DPLLRS_PRI0_LSB +: 2];
                    state_next.ref1Pri =
                        hostWrData[`DPLLRS_PRI1_LSB +: 2];
                end
                `DPLLRS_DIS_STATE_ADDR:
                begin
                    state_next.ref0Excl   =
                        hostWrData[`DPLLRS_DIS0_BIT];
                    state_next.ref1Excl   =
                        hostWrData[`DPLLRS_DIS1_BIT];
                    state_next.stateForce =
                        hostWrData[`DPLLRS_STATE_LSB +: 2];
                end
                `DPLLRS_R0_PRE_HI_ADDR:
                    state_next.ref0Prediv[20:16] = hostWrData[4:0];
                `DPLLRS_R0_PRE_MID_ADDR:
                    state_next.ref0Prediv[15:8]  = hostWrData;
                `DPLLRS_R0_PRE_LO_ADDR:
                    state_next.ref0Prediv[7:0]   = hostWrData;
                `DPLLRS_R1_PRE_HI_ADDR:
                    state_next.ref1Prediv[20:16] = hostWrData[4:0];
                `DPLLRS_R1_PRE_MID_ADDR:
                    state_next.ref1Prediv[15:8]  = hostWrData;
                `DPLLRS_R1_PRE_LO_ADDR:
                    state_next.ref1Prediv[7:0]   = hostWrData;
                default:
                    state_next.rdValid = state_next.rdValid;
            endcase
        end

        // modulator decode: off, or order one to three
        state_next.modEnable = (state_next.modOrder != 2'h0);
        // gain kept in halves so 0.5 stays an integer factor
        unique case (state_next.oscGain)
            2'h0: state_next.oscGainHalves = 4'h1;
            2'h1: state_next.oscGainHalves = 4'h2;
            2'h2: state_next.oscGainHalves = 4'h4;
            2'h3: state_next.oscGainHalves = 4'h8;
        endcase
        // dither amplitude doubles per code step above zero
        if (state_next.ditherGain == 3'h0)
            state_next.ditherLsbs = 7'h00;
        else
            state_next.ditherLsbs =
                7'(7'h01 << (state_next.ditherGain - 3'h1));

        // feedback: codes 11x are unused and fall back to internal
        state_next.fbExternal = (state_next.fbSource[2:1] == 2'h2);
        state_next.fbRef      = state_next.fbExternal &
                                state_next.fbSource[0];

        // best eligible reference; ties go to reference 0
        elig0 = refValid[0] & ~state_next.ref0Excl;
        elig1 = refValid[1] & ~state_next.ref1Excl;
        if (elig0 && elig1)
            bestSel = (dpllrs_rank(state_next.ref1Pri) <
                       dpllrs_rank(state_next.ref0Pri)) ?
                      dpllrs_pkg::SEL_REF1 : dpllrs_pkg::SEL_REF0;
        else if (elig0)
            bestSel = dpllrs_pkg::SEL_REF0;
        else if (elig1)
            bestSel = dpllrs_pkg::SEL_REF1;

        // non-revertive keeps a still-eligible reference
        curElig = ((state_reg.sel == dpllrs_pkg::SEL_REF0) && elig0) ||
                  ((state_reg.sel == dpllrs_pkg::SEL_REF1) && elig1);

        // manual and forced modes ignore validity on purpose
        unique case (state_next.refSelMode)
            dpllrs_pkg::REFSEL_AUTO:
            begin
                if (curElig && !state_next.revertEn)
                    state_next.sel = state_reg.sel;
                else
                    state_next.sel = bestSel;
            end
            dpllrs_pkg::REFSEL_MANUAL:
                state_next.sel = gpioRefSel ? dpllrs_pkg::SEL_REF1 :
                                              dpllrs_pkg::SEL_REF0;
            dpllrs_pkg::REFSEL_FORCE0:
                state_next.sel = dpllrs_pkg::SEL_REF0;
            dpllrs_pkg::REFSEL_FORCE1:
                state_next.sel = dpllrs_pkg::SEL_REF1;
            default:
                state_next.sel = state_reg.sel; // reserved: hold
        endcase
        state_next.activePrediv = dpllrs_prediv(state_next.sel,
            state_next.ref0Prediv, state_next.ref1Prediv);

        // read data: reserved bits and unmapped bytes read zero
        unique case (hostAddr)
            `DPLLRS_MOD_CFG_ADDR:
                rdByte = {state_reg.modOrder, state_reg.oscGain,
                          state_reg.ditherGain, 1'b0};
            `DPLLRS_SEL_CTRL_ADDR:
                rdByte = {state_reg.refSelMode, state_reg.fbSource,
                          state_reg.revertEn, state_reg.phaseMode};
            `DPLLRS_PRIORITY_ADDR:
                rdByte = {4'h0, state_reg.ref1Pri, state_reg.ref0Pri};
            `DPLLRS_DIS_STATE_ADDR:
                rdByte = {2'h0, state_reg.ref1Excl, state_reg.ref0Excl,
                          2'h0, state_reg.stateForce};
            `DPLLRS_R0_PRE_HI_ADDR:
                rdByte = {3'h0, state_reg.ref0Prediv[20:16]};
            `DPLLRS_R0_PRE_MID_ADDR:
                rdByte = state_reg.ref0Prediv[15:8];
            `DPLLRS_R0_PRE_LO_ADDR:
                rdByte = state_reg.ref0Prediv[7:0];
            `DPLLRS_R1_PRE_HI_ADDR:
                rdByte = {3'h0, state_reg.ref1Prediv[20:16]};
            `DPLLRS_R1_PRE_MID_ADDR:
                rdByte = state_reg.ref1Prediv[15:8];
            `DPLLRS_R1_PRE_LO_ADDR:
                rdByte = state_reg.ref1Prediv[7:0];
            default:
                rdByte = 8'h00;
        endcase
        // read shows contents before a same-cycle write
        state_next.rdValid = hostRead;
        if (hostRead)
            state_next.rdData = rdByte;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // single register bank for all state
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state_reg <= DPLLRS_RST;
        else
            state_reg <= state_next;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------

    // every output taken straight from the bank
    assign hostRdData          = state_reg.rdData;
    assign hostRdValid         = state_reg.rdValid;
    assign modulatorOrderA     = state_reg.modOrder;
    assign modulatorEnableA    = state_reg.modEnable;
    assign oscErrorGainHalvesA = state_reg.oscGainHalves;
    assign ditherLsbsA         = state_reg.ditherLsbs;
    assign revertiveEnableB    = state_reg.revertEn;
    assign switchPhaseModeB    = state_reg.phaseMode;
    assign stateForceB         = state_reg.stateForce;
    assign feedbackExternalB   = state_reg.fbExternal;
    assign feedbackRefB        = state_reg.fbRef;
    assign activeRefB          = state_reg.sel;
    assign activePredivB       = state_reg.activePrediv;

endmodule : dpllrs_top

// >>> hdl/dpllrs_regs.svh
// register offsets, field positions and reset values of the
// reference selection and modulator configuration bank
// assumes 16-bit host addresses and byte-wide registers
`ifndef DPLLRS_REGS_SVH
`define DPLLRS_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define DPLLRS_MOD_CFG_ADDR     16'h0038
`define DPLLRS_SEL_CTRL_ADDR    16'h003B
`define DPLLRS_PRIORITY_ADDR    16'h003C
`define DPLLRS_DIS_STATE_ADDR   16'h003D
`define DPLLRS_R0_PRE_HI_ADDR   16'h003E
`define DPLLRS_R0_PRE_MID_ADDR  16'h003F
`define DPLLRS_R0_PRE_LO_ADDR   16'h0040
`define DPLLRS_R1_PRE_HI_ADDR   16'h0041
`define DPLLRS_R1_PRE_MID_ADDR  16'h0042
`define DPLLRS_R1_PRE_LO_ADDR   16'h0043

// ----------------------------------------------------------------
// field positions (lsb of each field)
// ----------------------------------------------------------------
`define DPLLRS_MOD_ORDER_LSB    6
`define DPLLRS_OSC_GAIN_LSB     4
`define DPLLRS_DITHER_LSB       1
`define DPLLRS_REFSEL_LSB       5
`define DPLLRS_FBSEL_LSB        2
`define DPLLRS_REVERT_BIT       1
`define DPLLRS_SWMODE_BIT       0
`define DPLLRS_PRI1_LSB         2
`define DPLLRS_PRI0_LSB         0
`define DPLLRS_DIS1_BIT         5
`define DPLLRS_DIS0_BIT         4
`define DPLLRS_STATE_LSB        0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPLLRS_MOD_ORDER_RST    2'h3
`define DPLLRS_OSC_GAIN_RST     2'h1
`define DPLLRS_DITHER_RST       3'h0
`define DPLLRS_REFSEL_RST       3'h0
`define DPLLRS_FBSEL_RST        3'h0
`define DPLLRS_REVERT_RST       1'h1
`define DPLLRS_SWMODE_RST       1'h1
`define DPLLRS_PRI0_RST         2'h0
`define DPLLRS_PRI1_RST         2'h1
`define DPLLRS_DIS_RST          1'h0
`define DPLLRS_STATE_RST        2'h0
`define DPLLRS_PREDIV_RST       21'h000000

`endif

// >>> hdl/dpllrs_pkg.sv
// types shared by the reference selection configuration bank
// assumes dpllrs_regs.svh is compiled alongside
package dpllrs_pkg;

    // ------------------------------------------------------------
    // selection mode encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        REFSEL_AUTO   = 3'h0,
        REFSEL_MANUAL = 3'h1,
        REFSEL_FORCE0 = 3'h4,
        REFSEL_FORCE1 = 3'h5
    } dpllrs_refsel_t;

    // which reference the second loop follows
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_REF0,
        SEL_REF1
    } dpllrs_sel_t;

    // ------------------------------------------------------------
    // whole state of the bank
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  modOrder;
        logic [1:0]  oscGain;
        logic [2:0]  ditherGain;
        logic [2:0]  refSelMode;
        logic [2:0]  fbSource;
        logic        revertEn;
        logic        phaseMode;
        logic [1:0]  ref0Pri;
        logic [1:0]  ref1Pri;
        logic        ref0Excl;
        logic        ref1Excl;
        logic [1:0]  stateForce;
        logic [20:0] ref0Prediv;
        logic [20:0] ref1Prediv;
        dpllrs_sel_t sel;
        logic [20:0] activePrediv;
        logic        modEnable;
        logic [3:0]  oscGainHalves;
        logic [6:0]  ditherLsbs;
        logic        fbExternal;
        logic        fbRef;
        logic [7:0]  rdData;
        logic        rdValid;
    } dpllrs_state_t;

endpackage : dpllrs_pkg

// >>> sim/dpllrs_chk.sv
// concurrent checks on the ports of the reference selection bank
// assumes it is bound onto dpllrs_top; one clock, sync reset rst
`timescale 1ns/10ps
`include "dpllrs_regs.svh"
module dpllrs_chk
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst,
    // host port
    input wire logic [15:0] hostAddr,
    input wire logic        hostWrite,
    input wire logic [7:0]  hostWrData,
    // reference status
    input wire logic [1:0]  refValid,
    input wire logic        gpioRefSel,
    // decoded settings
    input wire logic [1:0]  modulatorOrderA,
    input wire logic        modulatorEnableA,
    input wire logic [3:0]  oscErrorGainHalvesA,
    input wire logic [6:0]  ditherLsbsA,
    input wire logic [1:0]  stateForceB,
    input wire logic        feedbackExternalB,
    input wire logic        feedbackRefB,
    input wire logic [1:0]  activeRefB,
    input wire logic [20:0] activePredivB
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------
    // helper: shadow of the selection mode field
    // ------------------------------------------------
    logic       wrMod;
    logic       wrSel;
    logic       wrDis;
    logic [2:0] selMode_reg;
    assign wrMod = hostWrite && (hostAddr == `DPLLRS_MOD_CFG_ADDR);
    assign wrSel = hostWrite && (hostAddr == `DPLLRS_SEL_CTRL_ADDR);
    assign wrDis = hostWrite && (hostAddr == `DPLLRS_DIS_STATE_ADDR);
    // mode is not visible at the ports, so rebuild it from writes
    always_ff @(posedge core_clk)
        if (rst)
            selMode_reg <= 3'h0;
        else if (wrSel)
            selMode_reg <= hostWrData[7:5];

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_order_enable: assert property (wrMod |=>
        modulatorOrderA == $past(hostWrData[7:6]) &&
        modulatorEnableA == ($past(hostWrData[7:6]) != 2'h0))
        else $error("modulator order or enable wrong");
    a_gain_scale: assert property (wrMod |=>
        oscErrorGainHalvesA == (4'h1 << $past(hostWrData[5:4])))
        else $error("oscillator gain wrong");
    a_dither_lsbs: assert property (wrMod |=>
        ditherLsbsA == (($past(hostWrData[3:1]) == 3'h0) ? 7'h00 :
        (7'h01 << ($past(hostWrData[3:1]) - 3'h1))))
        else $error("dither gain wrong");
    a_fb_decode: assert property (wrSel |=>
        feedbackExternalB == ($past(hostWrData[4:3]) == 2'h2) &&
        feedbackRefB == ($past(hostWrData[4:2]) == 3'h5))
        else $error("feedback decode wrong");
    a_state_write: assert property (wrDis |=>
        stateForceB == $past(hostWrData[1:0]))
        else $error("state control wrong");
    a_prediv_none: assert property (
        activeRefB == 2'h0 |-> activePredivB == 21'h000000)
        else $error("pre-divider not zero with no reference");
    a_force_ref: assert property (
        selMode_reg[2:1] == 2'h2 && !wrSel |=>
        activeRefB == ($past(selMode_reg[0]) ? 2'h2 : 2'h1))
        else $error("forced reference not followed");
    a_manual_pin: assert property (
        selMode_reg == 3'h1 && !wrSel |=>
        activeRefB == ($past(gpioRefSel) ? 2'h2 : 2'h1))
        else $error("manual pin selection not followed");
    a_auto_none: assert property (
        selMode_reg == 3'h0 && !wrSel && refValid == 2'h0 |=>
        activeRefB == 2'h0)
        else $error("reference chosen with none valid");

    // main scenarios reached
    c_force_one: cover property (selMode_reg == 3'h5);
    c_auto_second: cover property (selMode_reg == 3'h0 && activeRefB == 2'h2);
    c_mod_off: cover property (wrMod && hostWrData[7:6] == 2'h0);
endmodule : dpllrs_chk

// >>> sim/dpllrs_tb_top.sv
// self-checking bench for the reference selection bank
// assumes dpllrs_top and dpllrs_chk are compiled with the header
`timescale 1ns/10ps
module dpllrs_tb_top;
    logic        core_clk;
    logic        rst;
    logic [15:0] hostAddr;
    logic        hostWrite;
    logic        hostRead;
    logic [7:0]  hostWrData;
    logic [7:0]  hostRdData;
    logic        hostRdValid;
    logic [1:0]  refValid;
    logic        gpioRefSel;
    logic [1:0]  modulatorOrderA;
    logic        modulatorEnableA;
    logic [3:0]  oscErrorGainHalvesA;
    logic [6:0]  ditherLsbsA;
    logic        revertiveEnableB;
    logic        switchPhaseModeB;
    logic [1:0]  stateForceB;
    logic        feedbackExternalB;
    logic        feedbackRefB;
    logic [1:0]  activeRefB;
    logic [20:0] activePredivB;
    int          errTotal;
    int          nChecks;

    dpllrs_top i_dut (.core_clk(core_clk), .rst(rst), .hostAddr(hostAddr),
        .hostWrite(hostWrite), .hostRead(hostRead), .hostWrData(hostWrData),
        .hostRdData(hostRdData), .hostRdValid(hostRdValid),
        .refValid(refValid), .gpioRefSel(gpioRefSel),
        .modulatorOrderA(modulatorOrderA), .modulatorEnableA(modulatorEnableA),
        .oscErrorGainHalvesA(oscErrorGainHalvesA), .ditherLsbsA(ditherLsbsA),
        .revertiveEnableB(revertiveEnableB),
        .switchPhaseModeB(switchPhaseModeB), .stateForceB(stateForceB),
        .feedbackExternalB(feedbackExternalB), .feedbackRefB(feedbackRefB),
        .activeRefB(activeRefB), .activePredivB(activePredivB));

    // 25 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // --------------------------------------------
    // bus and compare tasks
    // --------------------------------------------
    task automatic cmpVal(string name, logic [31:0] exp, logic [31:0] got);
        nChecks++;
        if (got !== exp)
        begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmpVal

    // one write strobe; returns once the write has landed
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(posedge core_clk);
        hostAddr   <= a;
        hostWrData <= d;
        hostWrite  <= 1'b1;
        @(posedge core_clk);
        hostWrite  <= 1'b0;
        #1;
    endtask : wr

    task automatic rdChk(logic [15:0] a, logic [7:0] e);
        @(posedge core_clk);
        hostAddr <= a;
        hostRead <= 1'b1;
        @(posedge core_clk);
        hostRead <= 1'b0;
        #1;
        cmpVal("read valid", 32'h1, hostRdValid);
        cmpVal("read data", e, hostRdData);
    endtask : rdChk

    // change reference status, then check the chosen reference
    task automatic refChk(logic [1:0] v, logic g, logic [1:0] e,
                          logic [20:0] p);
        @(posedge core_clk);
        refValid   <= v;
        gpioRefSel <= g;
        @(posedge core_clk);
        #1;
        cmpVal("active ref", e, activeRefB);
        cmpVal("active prediv", p, activePredivB);
    endtask : refChk

    // --------------------------------------------
    // scenarios
    // --------------------------------------------
    task automatic t_reset;
        // look after the edge so the reset values have settled
        #1;
        cmpVal("gain", 32'h2, oscErrorGainHalvesA);
        cmpVal("enable", 32'h1, modulatorEnableA);
        cmpVal("revert", 32'h1, revertiveEnableB);
        cmpVal("phase mode", 32'h1, switchPhaseModeB);
        rdChk(16'h0038, 8'hD0);
        rdChk(16'h003B, 8'h03);
        rdChk(16'h003C, 8'h04);
        rdChk(16'h003D, 8'h00);
        for (int i = 0; i < 6; i++)
            rdChk(16'h003E + 16'(i), 8'h00);
    endtask : t_reset

    // every order, gain and dither code; reserved bit 0 written zero
    task automatic t_modulator;
        for (int i = 0; i < 8; i++)
        begin
            wr(16'h0038, {2'(i), 2'(i), 3'(i), 1'b0});
            cmpVal("order", i % 4, modulatorOrderA);
            cmpVal("enable", (i % 4) != 0, modulatorEnableA);
            cmpVal("gain", 1 << (i % 4), oscErrorGainHalvesA);
            cmpVal("dither", i ? 1 << (i - 1) : 0, ditherLsbsA);
        end
    endtask : t_modulator

    task automatic t_feedback;
        for (int f = 0; f < 8; f++)
        begin
            wr(16'h003B, {3'h0, 3'(f), 2'(f)});
            cmpVal("fb ext", f == 4 || f == 5, feedbackExternalB);
            cmpVal("fb ref", f == 5, feedbackRefB);
            cmpVal("revert", (f >> 1) % 2, revertiveEnableB);
            cmpVal("phase mode", f % 2, switchPhaseModeB);
        end
    endtask : t_feedback

    // byte-wise pre-dividers, read back, and an unmapped place
    task automatic t_prediv;
        logic [7:0] pb [6];
        pb = '{8'h1F, 8'h23, 8'h45, 8'h0A, 8'hBC, 8'hDE};
        for (int i = 0; i < 6; i++)
            wr(16'h003E + 16'(i), pb[i]);
        for (int i = 0; i < 6; i++)
            rdChk(16'h003E + 16'(i), pb[i]);
        wr(16'h0044, 8'h00);
        rdChk(16'h0044, 8'h00);
    endtask : t_prediv

    // forced, reserved, manual and automatic selection codes
    task automatic t_select;
        wr(16'h003B, 8'h83);
        refChk(2'h0, 1'b0, 2'h1, 21'h1F2345);
        wr(16'h003B, 8'hA3);
        refChk(2'h0, 1'b0, 2'h2, 21'h0ABCDE);
        wr(16'h003B, 8'h43);
        refChk(2'h3, 1'b0, 2'h2, 21'h0ABCDE);
        wr(16'h003B, 8'h23);
        refChk(2'h0, 1'b0, 2'h1, 21'h1F2345);
        refChk(2'h0, 1'b1, 2'h2, 21'h0ABCDE);
        wr(16'h003B, 8'h03);
        refChk(2'h0, 1'b0, 2'h0, 21'h000000);
    endtask : t_select

    task automatic t_auto;
        refChk(2'h3, 1'b0, 2'h1, 21'h1F2345);
        refChk(2'h2, 1'b0, 2'h2, 21'h0ABCDE);
        refChk(2'h3, 1'b0, 2'h1, 21'h1F2345);
        wr(16'h003B, 8'h01);
        refChk(2'h2, 1'b0, 2'h2, 21'h0ABCDE);
        refChk(2'h3, 1'b0, 2'h2, 21'h0ABCDE);
        wr(16'h003B, 8'h03);
        wr(16'h003C, 8'h01);
        refChk(2'h3, 1'b0, 2'h2, 21'h0ABCDE);
        wr(16'h003D, 8'h20);
        refChk(2'h3, 1'b0, 2'h1, 21'h1F2345);
        for (int s = 0; s < 4; s++)
        begin
            wr(16'h003D, 8'h30 | 8'(s));
            cmpVal("state", s, stateForceB);
            refChk(2'h3, 1'b0, 2'h0, 21'h000000);
        end
    endtask : t_auto

    task automatic wrapUp;
        if (errTotal == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrapUp

    // --------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------
    initial
    begin
        errTotal   = 0;
        nChecks    = 0;
        rst        = 1'b1;
        hostAddr   = 16'h0000;
        hostWrite  = 1'b0;
        hostRead   = 1'b0;
        hostWrData = 8'h00;
        refValid   = 2'h0;
        gpioRefSel = 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_modulator();
        t_feedback();
        t_prediv();
        t_select();
        t_auto();
        wrapUp();
    end

    // a hung handshake would otherwise stall the run for ever
    initial
    begin
        repeat (3000) @(posedge core_clk);
        errTotal++;
        wrapUp();
    end
endmodule : dpllrs_tb_top

bind dpllrs_top dpllrs_chk i_chk (.core_clk(core_clk), .rst(rst),
    .hostAddr(hostAddr), .hostWrite(hostWrite), .hostWrData(hostWrData),
    .refValid(refValid), .gpioRefSel(gpioRefSel),
    .modulatorOrderA(modulatorOrderA), .modulatorEnableA(modulatorEnableA),
    .oscErrorGainHalvesA(oscErrorGainHalvesA), .ditherLsbsA(ditherLsbsA),
    .stateForceB(stateForceB), .feedbackExternalB(feedbackExternalB),
    .feedbackRefB(feedbackRefB), .activeRefB(activeRefB),
    .activePredivB(activePredivB));
